// ==== design/ebcr_pkg.sv ====
/*
 * constants, field layouts and carrier types of the external bus
 * configuration register bank.
 * assumes a 32-bit ahb-lite register bus and a bus cycle sequencer
 * that reads the configuration carrier.
 */
// Notes on behaviour
// - width bit one: area is 8-bit
// - width bit zero: area is 16-bit
// - state bit: zero two-state, one three-state
// - state bits meaningless in single-chip mode
// - state register resets to ff
// - wait control resets to f3
// - wait control upper nibble reads ones
// - bits 3:2 select the wait mode
// - bits 1:0 give 0 to 3 waits
// - enable bit zero: pin wait mode 0
// - wait enable register resets to ff
// - wait enables meaningless in single-chip mode
// - cleared address bits make pins upper address
// - address bits locked outside modes 3,4,6
// - release register bits 4:1 read ones
// - release bit zero: bus never released
// - release register resets to fe
// - select enable bit drives area select output
// - select register ignores writes in single-chip mode
// - select register resets to 0f
package ebcr_pkg;

   ////////////////////////////////////////////////////////////////////
   // register byte offsets on the bus
   localparam logic [7:0] OFF_AREA_WIDTH = 8'h00;
   localparam logic [7:0] OFF_ACCESS_STATE = 8'h04;
   localparam logic [7:0] OFF_WAIT_CONTROL = 8'h08;
   localparam logic [7:0] OFF_WAIT_ENABLE = 8'h0C;
   localparam logic [7:0] OFF_BUS_RELEASE = 8'h10;
   localparam logic [7:0] OFF_CHIP_SELECT = 8'h14;

   ////////////////////////////////////////////////////////////////////
   // values after reset and hardware standby
   localparam logic [7:0] RST_WIDTH_WIDE = 8'h00;
   localparam logic [7:0] RST_WIDTH_NARROW = 8'hFF;
   localparam logic [7:0] RST_ACCESS_STATE = 8'hFF;
   localparam logic [7:0] RST_WAIT_CONTROL = 8'hF3;
   localparam logic [7:0] RST_WAIT_ENABLE = 8'hFF;
   localparam logic [7:0] RST_BUS_RELEASE = 8'hFE;
   localparam logic [7:0] RST_CHIP_SELECT = 8'h0F;

   ////////////////////////////////////////////////////////////////////
   // field positions and fixed-one masks
   localparam int WAIT_MODE_LSB = 2;
   localparam int WAIT_COUNT_LSB = 0;
   localparam int ADDR_EN_LSB = 5;
   localparam int RELEASE_BIT = 0;
   localparam int SELECT_EN_LSB = 4;
   localparam logic [7:0] WCR_ONES = 8'hF0;
   localparam logic [7:0] BRC_ONES = 8'h1E;
   localparam logic [7:0] CSC_ONES = 8'h0F;
   localparam logic [7:0] BRC_ADDR_MASK = 8'hE0;
   localparam logic [7:0] BRC_REL_MASK = 8'h01;
   localparam logic [7:0] CSC_EN_MASK = 8'hF0;

   ////////////////////////////////////////////////////////////////////
   // operating modes
   localparam logic [2:0] MODE_2 = 3'h2;
   localparam logic [2:0] MODE_3 = 3'h3;
   localparam logic [2:0] MODE_4 = 3'h4;
   localparam logic [2:0] MODE_6 = 3'h6;
   localparam logic [2:0] MODE_SINGLE = 3'h7;

   // wait mode encodings
   typedef enum logic [1:0] {
      WAIT_PROGRAMMED = 2'b00,
      WAIT_NONE = 2'b01,
      WAIT_PIN_MODE1 = 2'b10,
      WAIT_PIN_AUTO = 2'b11
   } ebcr_wait_mode_t;

   // ahb-lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic HRESP_OKAY = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // configuration carried to the bus cycle sequencer
   typedef struct packed {
      logic [7:0] area_8bit;       // one: 8-bit area, zero: 16-bit
      logic [7:0] area_three_state; // one: three-state external access
      logic [7:0] area_wait_ctrl;  // wait controller active per area
      ebcr_wait_mode_t wait_mode;  // wait mode field
      logic [1:0] wait_count;      // wait states inserted
      logic [2:0] addr_hi_en;      // a23..a21 pin function selected
      logic bus_release_enable;    // external master may take the bus
      logic [3:0] upper_select_enables; // area 7..4 select outputs
   } ebcr_cfg_t;

   localparam ebcr_cfg_t CFG_RST = '{
      area_8bit: 8'hFF,
      area_three_state: 8'h00,
      area_wait_ctrl: 8'h00,
      wait_mode: WAIT_PROGRAMMED,
      wait_count: 2'h3,
      addr_hi_en: 3'h0,
      bus_release_enable: 1'b0,
      upper_select_enables: 4'h0
   };

endpackage

// ==== design/ebcr_regs.sv ====
/*
 * external bus configuration register bank with an ahb-lite slave.
 * assumes a single ahb-lite master, mode and hardware standby pins
 * from outside the clock domain, and a bus sequencer on clk that
 * flags its cycles with bus_cycle_active.
 */
`timescale 1ns/100ps
module ebcr_regs
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [2:0] mode_pins,
   input wire logic hw_standby,
   input wire logic bus_cycle_active,
   output ebcr_pkg::ebcr_cfg_t cfg
);

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [2:0] mode_s1_q; // first stage, read only by second
   logic [2:0] mode_q; // synchronised operating mode
   logic stby_s1_q; // first stage, read only by second
   logic stby_q; // synchronised hardware standby
   logic init; // reset or hardware standby

   // two flops on the mode pins; they run through reset so that the
   // width reset value sees the mode held on the pins during reset
   always_ff @(posedge clk)
   begin
      mode_s1_q <= mode_pins;
      mode_q <= mode_s1_q;
   end

   // two flops on the standby pin, cleared by reset
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         stby_s1_q <= 1'b0;
         stby_q <= 1'b0;
      end
      else
      begin
         stby_s1_q <= hw_standby;
         stby_q <= stby_s1_q;
      end
   end

   // software standby is not an input: registers simply keep their value
   assign init = !rst_b || stby_q;

   ////////////////////////////////////////////////////////////////////
   // mode decode
   logic mode_single; // single-chip mode
   logic mode_addr_ok; // upper address bits modifiable
   logic mode_wide_rst; // width register resets to 16-bit

   assign mode_single = (mode_q == ebcr_pkg::MODE_SINGLE);
   assign mode_addr_ok = (mode_q == ebcr_pkg::MODE_3) || (mode_q == ebcr_pkg::MODE_4) ||
      (mode_q == ebcr_pkg::MODE_6);
   assign mode_wide_rst = (mode_q == ebcr_pkg::MODE_2) || (mode_q == ebcr_pkg::MODE_4);

   ////////////////////////////////////////////////////////////////////
   // ahb-lite address and data phase
   logic acc; // address phase taken
   logic wr_pend_q; // write data phase in progress
   logic [7:0] wr_off_q; // offset of the pending write
   logic rd_acc; // read taken this cycle

   // zero-wait slave: every transfer takes one data phase cycle
   assign acc = hsel && hready && (htrans == ebcr_pkg::HTRANS_NONSEQ);
   assign rd_acc = acc && !hwrite;

   // remember a write until its data phase
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wr_pend_q <= 1'b0;
         wr_off_q <= 8'h00;
      end
      else
      begin
         wr_pend_q <= acc && hwrite;
         wr_off_q <= haddr[7:0];
      end
   end

   // the slave stretches only in reset, where hreadyout is low, and always answers okay
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         hreadyout <= 1'b0;
         hresp <= ebcr_pkg::HRESP_OKAY;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= ebcr_pkg::HRESP_OKAY;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] width_q; // area width bits
   logic [7:0] width_d;
   logic [7:0] astate_q; // access state bits
   logic [7:0] astate_d;
   logic [3:0] wctl_q; // wait mode and count
   logic [3:0] wctl_d;
   logic [7:0] wen_q; // wait enable bits
   logic [7:0] wen_d;
   logic [7:0] brc_q; // bus release register, reserved bits kept one
   logic [7:0] brc_d;
   logic [7:0] csc_q; // chip select register, reserved bits kept one
   logic [7:0] csc_d;
   logic [7:0] wbyte; // written byte

   assign wbyte = hwdata[7:0];

   // next values: the write of the current data phase
   always_comb
   begin
      width_d = width_q;
      astate_d = astate_q;
      wctl_d = wctl_q;
      wen_d = wen_q;
      brc_d = brc_q;
      csc_d = csc_q;
      if (wr_pend_q)
      begin
         case (wr_off_q)
            ebcr_pkg::OFF_AREA_WIDTH: width_d = wbyte;
            ebcr_pkg::OFF_ACCESS_STATE: astate_d = wbyte;
            ebcr_pkg::OFF_WAIT_CONTROL: wctl_d = wbyte[3:0];
            ebcr_pkg::OFF_WAIT_ENABLE: wen_d = wbyte;
            ebcr_pkg::OFF_BUS_RELEASE:
            begin
               // release bit always writable, address bits per mode
               brc_d = (brc_q & ~ebcr_pkg::BRC_REL_MASK) |
                  (wbyte & ebcr_pkg::BRC_REL_MASK);
               if (mode_addr_ok)
               begin
                  brc_d = (brc_d & ~ebcr_pkg::BRC_ADDR_MASK) |
                     (wbyte & ebcr_pkg::BRC_ADDR_MASK);
               end
            end
            ebcr_pkg::OFF_CHIP_SELECT:
            begin
               // write ignored in single-chip mode
               if (!mode_single)
               begin
                  csc_d = (wbyte & ebcr_pkg::CSC_EN_MASK) | ebcr_pkg::CSC_ONES;
               end
            end
            default:
            begin
               // unmapped offset: write dropped
               width_d = width_q;
            end
         endcase
      end
   end

   // width register, reset value follows the mode
   always_ff @(posedge clk)
   begin
      if (init)
      begin
         width_q <= mode_wide_rst ? ebcr_pkg::RST_WIDTH_WIDE : ebcr_pkg::RST_WIDTH_NARROW;
      end
      else
      begin
         width_q <= width_d;
      end
   end

   // timing registers: state, wait control, wait enable
   always_ff @(posedge clk)
   begin
      if (init)
      begin
         astate_q <= ebcr_pkg::RST_ACCESS_STATE;
         wctl_q <= ebcr_pkg::RST_WAIT_CONTROL[3:0];
         wen_q <= ebcr_pkg::RST_WAIT_ENABLE;
      end
      else
      begin
         astate_q <= astate_d;
         wctl_q <= wctl_d;
         wen_q <= wen_d;
      end
   end

   // pin function registers: release and chip select
   always_ff @(posedge clk)
   begin
      if (init)
      begin
         brc_q <= ebcr_pkg::RST_BUS_RELEASE;
         csc_q <= ebcr_pkg::RST_CHIP_SELECT;
      end
      else
      begin
         brc_q <= brc_d | ebcr_pkg::BRC_ONES;
         csc_q <= csc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data, taken from next values so a write just before is seen
   logic [7:0] rd_byte; // selected register byte

   // read mux with fixed-one bits
   always_comb
   begin
      case (haddr[7:0])
         ebcr_pkg::OFF_AREA_WIDTH: rd_byte = width_d;
         ebcr_pkg::OFF_ACCESS_STATE: rd_byte = astate_d;
         ebcr_pkg::OFF_WAIT_CONTROL: rd_byte = ebcr_pkg::WCR_ONES | {4'h0, wctl_d};
         ebcr_pkg::OFF_WAIT_ENABLE: rd_byte = wen_d;
         ebcr_pkg::OFF_BUS_RELEASE: rd_byte = brc_d | ebcr_pkg::BRC_ONES;
         ebcr_pkg::OFF_CHIP_SELECT: rd_byte = csc_d;
         default: rd_byte = 8'h00;
      endcase
   end

   // data phase read data, zero outside reads
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         hrdata <= 32'h0000_0000;
      end
      else
      begin
         hrdata <= rd_acc ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // configuration to the sequencer
   ebcr_pkg::ebcr_cfg_t cfg_w; // settings as programmed now
   logic [7:0] ext_three; // three-state areas in expanded modes

   // single-chip mode fixes on-chip timing, so state bits fall away
   assign ext_three = mode_single ? 8'h00 : astate_q;

   always_comb
   begin
      cfg_w.area_8bit = width_q;
      cfg_w.area_three_state = ext_three;
      // wait control only for three-state areas, never in single-chip
      cfg_w.area_wait_ctrl = ext_three & wen_q;
      cfg_w.wait_mode = ebcr_pkg::ebcr_wait_mode_t'(wctl_q[ebcr_pkg::WAIT_MODE_LSB +: 2]);
      cfg_w.wait_count = wctl_q[ebcr_pkg::WAIT_COUNT_LSB +: 2];
      // cleared enable bit selects the address function
      cfg_w.addr_hi_en = mode_addr_ok ? ~brc_q[ebcr_pkg::ADDR_EN_LSB +: 3] : 3'h0;
      cfg_w.bus_release_enable = brc_q[ebcr_pkg::RELEASE_BIT];
      cfg_w.upper_select_enables = csc_q[ebcr_pkg::SELECT_EN_LSB +: 4];
   end

   // settings only move between external bus cycles
   always_ff @(posedge clk)
   begin
      if (init)
      begin
         cfg <= ebcr_pkg::CFG_RST;
      end
      else if (!bus_cycle_active)
      begin
         cfg <= cfg_w;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_astate_rst;
      $past(init) |-> astate_q == ebcr_pkg::RST_ACCESS_STATE;
   endproperty
   a_astate_rst: assert property (p_astate_rst) else $error("access state reset wrong");

   property p_wctl_rst;
      $past(init) |-> (ebcr_pkg::WCR_ONES | {4'h0, wctl_q}) == ebcr_pkg::RST_WAIT_CONTROL;
   endproperty
   a_wctl_rst: assert property (p_wctl_rst) else $error("wait control reset wrong");

   property p_wcr_ones;
      rd_acc && haddr[7:0] == ebcr_pkg::OFF_WAIT_CONTROL |=> hrdata[7:4] == 4'hF;
   endproperty
   a_wcr_ones: assert property (p_wcr_ones) else $error("wait control high bits not one");

   property p_wen_rst;
      $past(init) |-> wen_q == ebcr_pkg::RST_WAIT_ENABLE;
   endproperty
   a_wen_rst: assert property (p_wen_rst) else $error("wait enable reset wrong");

   property p_brc_ones;
      rd_acc && haddr[7:0] == ebcr_pkg::OFF_BUS_RELEASE |=> hrdata[4:1] == 4'hF;
   endproperty
   a_brc_ones: assert property (p_brc_ones) else $error("release reserved bits not one");

   property p_brc_rst;
      $past(init) |-> brc_q == ebcr_pkg::RST_BUS_RELEASE;
   endproperty
   a_brc_rst: assert property (p_brc_rst) else $error("bus release reset wrong");

   property p_addr_lock;
      !init && wr_pend_q && wr_off_q == ebcr_pkg::OFF_BUS_RELEASE && !mode_addr_ok
         |=> brc_q[7:5] == $past(brc_q[7:5]);
   endproperty
   a_addr_lock: assert property (p_addr_lock) else $error("address enables changed");

   property p_csc_lock;
      !init && wr_pend_q && wr_off_q == ebcr_pkg::OFF_CHIP_SELECT && mode_single
         |=> csc_q == $past(csc_q);
   endproperty
   a_csc_lock: assert property (p_csc_lock) else $error("select register written");

   property p_csc_rst;
      $past(init) |-> csc_q == ebcr_pkg::RST_CHIP_SELECT;
   endproperty
   a_csc_rst: assert property (p_csc_rst) else $error("select register reset wrong");

   property p_cfg_hold;
      !init && bus_cycle_active |=> $stable(cfg);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("settings moved in a cycle");

   property p_single_wait;
      !init && !bus_cycle_active && mode_single |=> cfg.area_wait_ctrl == 8'h00 &&
         cfg.area_three_state == 8'h00;
   endproperty
   a_single_wait: assert property (p_single_wait) else $error("single-chip wait active");

   property p_release_sel;
      !init && !bus_cycle_active |=> cfg.bus_release_enable == $past(brc_q[0]);
   endproperty
   a_release_sel: assert property (p_release_sel) else $error("release enable wrong");

endmodule // ebcr_regs

// ==== tb/ebcr_seq_model.sv ====
/*
 * behavioural model of the bus cycle sequencer that reads the
 * configuration carrier of the register bank.
 * assumes cfg comes from the bank on the same clock.
 */
`timescale 1ns/100ps
module ebcr_seq_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [7:0] len,
   input wire logic [2:0] area,
   input wire ebcr_pkg::ebcr_cfg_t cfg,
   output logic bus_cycle_active,
   output logic cfg_moved,
   output logic wait_req
);
   logic [7:0] left_q; // cycles of the running bus cycle still to go
   ebcr_pkg::ebcr_cfg_t snap_q; // settings seen as the cycle began

   ////////////////////////////////////////////////////////////////////
   // length counter of one external bus cycle
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         left_q <= 8'h00;
      else if (start)
         left_q <= len;
      else if (left_q != 8'h00)
         left_q <= left_q - 8'h01;
   end

   // snapshot at cycle start, flag any change in mid-cycle
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         cfg_moved <= 1'b0;
      else if (left_q == len)
         snap_q <= cfg;
      else if (bus_cycle_active && cfg !== snap_q)
         cfg_moved <= 1'b1;
   end

   assign bus_cycle_active = (left_q != 8'h00);
   // the far side stretches only three-state areas
   assign wait_req = bus_cycle_active && cfg.area_three_state[area];
endmodule // ebcr_seq_model

// ==== tb/testbench.sv ====
/*
 * self-checking bench of the external bus configuration registers.
 * assumes one ahb-lite slave whose hreadyout is the bus hready.
 */
`timescale 1ns/100ps
module testbench;
   localparam logic [7:0] O_AW = ebcr_pkg::OFF_AREA_WIDTH;
   localparam logic [7:0] O_AS = ebcr_pkg::OFF_ACCESS_STATE;
   localparam logic [7:0] O_WC = ebcr_pkg::OFF_WAIT_CONTROL;
   localparam logic [7:0] O_WE = ebcr_pkg::OFF_WAIT_ENABLE;
   localparam logic [7:0] O_BR = ebcr_pkg::OFF_BUS_RELEASE;
   localparam logic [7:0] O_CS = ebcr_pkg::OFF_CHIP_SELECT;
   logic clk = 1'b0; // system clock
   logic rst_b, hsel, hwrite, hready, hreadyout, hresp, hw_standby;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, mode_pins, seq_area;
   logic bus_cycle_active, seq_start, cfg_moved, wait_req;
   logic [7:0] seq_len;
   ebcr_pkg::ebcr_cfg_t cfg; // settings seen by the sequencer
   int failures, cmp_count;

   ////////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;
   assign hready = hreadyout; // single slave

   ebcr_regs u_dut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .mode_pins(mode_pins), .hw_standby(hw_standby),
      .bus_cycle_active(bus_cycle_active), .cfg(cfg));
   ebcr_seq_model u_seq (.clk(clk), .rst_b(rst_b), .start(seq_start),
      .len(seq_len), .area(seq_area), .cfg(cfg),
      .bus_cycle_active(bus_cycle_active), .cfg_moved(cfg_moved),
      .wait_req(wait_req));

   ////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // compare one value
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask

   // bounded wait for an edge with hready high
   task automatic wait_ready();
      int n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 40);
      if (hreadyout !== 1'b1)
      begin
         failures++;
         report_and_stop();
      end
   endtask

   // one single word transfer, address phase then data phase
   task automatic xfer(input logic wr, input logic [7:0] off,
                       input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= ebcr_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {24'h00_0000, off};
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      check("hresp", 32'(hresp), 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] off, input logic [31:0] d);
      logic [31:0] rd;
      xfer(1'b1, off, d, rd);
   endtask

   task automatic rdc(input string what, input logic [7:0] off,
                      input logic [31:0] exp);
      logic [31:0] rd;
      xfer(1'b0, off, 32'h0000_0000, rd);
      check(what, rd, exp);
   endtask

   // reset with the mode pins held steady
   task automatic do_reset(input logic [2:0] mode);
      rst_b <= 1'b0;
      mode_pins <= mode;
      step(3);
      rst_b <= 1'b1;
      step(3);
   endtask

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_b = 1'b0; hsel = 1'b0; hwrite = 1'b0; hw_standby = 1'b0;
      haddr = 32'h0000_0000; hwdata = 32'h0000_0000; htrans = 2'h0;
      hsize = 3'h2; mode_pins = 3'h3; seq_area = 3'h1;
      seq_start = 1'b0; seq_len = 8'h00; failures = 0; cmp_count = 0;
      do_reset(ebcr_pkg::MODE_3);
      // reset values in an expanded mode
      rdc("width", O_AW, 32'h0000_00FF);
      rdc("state", O_AS, 32'h0000_00FF);
      rdc("wctl", O_WC, 32'h0000_00F3);
      rdc("wen", O_WE, 32'h0000_00FF);
      rdc("rel", O_BR, 32'h0000_00FE);
      rdc("sel", O_CS, 32'h0000_000F);
      check("c_3s", 32'(cfg.area_three_state), 32'h0000_00FF);
      check("c_wc", 32'(cfg.area_wait_ctrl), 32'h0000_00FF);
      check("c_rel", 32'(cfg.bus_release_enable), 32'h0000_0000);
      check("c_sel", 32'(cfg.upper_select_enables), 32'h0000_0000);
      // every wait mode with a matching wait count
      for (int i = 0; i < 4; i++)
      begin
         wr(O_WC, 32'(i * 5));
         rdc("wctl", O_WC, 32'h0000_00F0 | 32'(i * 5));
         check("c_mode", 32'(cfg.wait_mode), 32'(i));
         check("c_cnt", 32'(cfg.wait_count), 32'(i));
      end
      // mixed settings back to back, one unmapped hole
      wr(O_AW, 32'h0000_0081);
      wr(O_AS, 32'h0000_000F);
      wr(O_WE, 32'h0000_0005);
      wr(O_BR, 32'h0000_0001);
      wr(O_CS, 32'h0000_00A0);
      wr(8'h18, 32'h0000_00FF);
      rdc("hole", 8'h18, 32'h0000_0000);
      rdc("rel", O_BR, 32'h0000_001F);
      rdc("sel", O_CS, 32'h0000_00AF);
      check("c_w8", 32'(cfg.area_8bit), 32'h0000_0081);
      check("c_3s", 32'(cfg.area_three_state), 32'h0000_000F);
      check("c_wc", 32'(cfg.area_wait_ctrl), 32'h0000_0005);
      check("c_addr", 32'(cfg.addr_hi_en), 32'h0000_0007);
      check("c_rel", 32'(cfg.bus_release_enable), 32'h0000_0001);
      check("c_sel", 32'(cfg.upper_select_enables), 32'h0000_000A);
      // write during a long bus cycle
      seq_len <= 8'd30;
      seq_start <= 1'b1;
      step(1);
      seq_start <= 1'b0;
      wr(O_AS, 32'h0000_00AA);
      step(2);
      check("frozen", 32'(cfg.area_three_state), 32'h0000_000F);
      check("wait", 32'(wait_req), 32'h0000_0001);
      for (int n = 0; n < 60 && bus_cycle_active !== 1'b0; n++)
         step(1);
      if (bus_cycle_active !== 1'b0)
      begin
         failures++;
         report_and_stop();
      end
      step(2);
      check("moved", 32'(cfg_moved), 32'h0000_0000);
      check("c_3s", 32'(cfg.area_three_state), 32'h0000_00AA);
      // single-chip mode locks and masks
      mode_pins <= ebcr_pkg::MODE_SINGLE;
      step(4);
      wr(O_CS, 32'h0000_0050);
      wr(O_BR, 32'h0000_00FF);
      rdc("sel", O_CS, 32'h0000_00AF);
      rdc("rel", O_BR, 32'h0000_001F);
      check("c_3s", 32'(cfg.area_three_state), 32'h0000_0000);
      check("c_wc", 32'(cfg.area_wait_ctrl), 32'h0000_0000);
      check("c_addr", 32'(cfg.addr_hi_en), 32'h0000_0000);
      // mode 4: wide reset width, then hardware standby
      do_reset(ebcr_pkg::MODE_4);
      rdc("width", O_AW, 32'h0000_0000);
      wr(O_BR, 32'h0000_0000);
      rdc("rel", O_BR, 32'h0000_001E);
      wr(O_AS, 32'h0000_0000);
      wr(O_WC, 32'h0000_000C);
      wr(O_AW, 32'h0000_00FF);
      hw_standby <= 1'b1;
      step(6);
      hw_standby <= 1'b0;
      step(6);
      rdc("state", O_AS, 32'h0000_00FF);
      rdc("wctl", O_WC, 32'h0000_00F3);
      rdc("rel", O_BR, 32'h0000_00FE);
      rdc("width", O_AW, 32'h0000_0000);
      report_and_stop();
   end
endmodule // testbench
